// >>> design/ospc_pkg.sv
// Package with register map, field positions and timing constants for the clock controller
package ospc_pkg;

	// Register indices on the plain register port
	localparam logic [3:0] OSPC_ADDR_HF_CTRL   = 4'h0;	// hf_xosc_control_a
	localparam logic [3:0] OSPC_ADDR_LF_CTRL   = 4'h1;	// lf_xosc_control_a
	localparam logic [3:0] OSPC_ADDR_PLL_CTRL  = 4'h2;	// pll_control_a
	localparam logic [3:0] OSPC_ADDR_STATUS    = 4'h3;	// main_clock_status
	localparam logic [3:0] OSPC_ADDR_IRQ_STAT  = 4'h4;	// Sticky event flags
	localparam logic [3:0] OSPC_ADDR_IRQ_MASK  = 4'h5;	// Interrupt mask

	// Control register fields
	localparam int OSPC_BIT_ENABLE   = 0;	// Oscillator / PLL enable
	localparam int OSPC_BIT_HF_EXTERNAL_INPUT_SELECT    = 1;	// hf_external_input_select (1 = external clock)
	localparam int OSPC_BIT_PLLSRC   = 1;	// PLL source (1 = hf external oscillator)
	localparam int OSPC_BIT_RUNSTBY  = 7;	// run_in_standby

	// Status fields
	localparam int OSPC_BIT_EXTERNAL_CLOCK_READY_FLAG     = 0;	// external_clock_ready_flag
	localparam int OSPC_BIT_LFS      = 1;	// 32 kHz oscillator ready flag
	localparam int OSPC_BIT_PLL_READY_FLAG     = 2;	// pll_ready_flag

	// Reset values
	localparam logic [7:0] OSPC_CTRL_RST = 8'h00;
	localparam logic [2:0] OSPC_FLAG_RST = 3'h0;

	// PLL lock time and its cycle count at 40 MHz
	localparam int OSPC_CLK_MHZ      = 40;
	localparam int OSPC_PLL_LOCK_NS  = 400;
	localparam int OSPC_PLL_LOCK_CYC = (OSPC_PLL_LOCK_NS * OSPC_CLK_MHZ + 999) / 1000;
	localparam logic [7:0] OSPC_PLL_LOCK_MAX = 8'(OSPC_PLL_LOCK_CYC);

	// PLL controller states
	typedef enum logic [1:0]
	{
		OSPC_PLL_OFF  = 2'b00,
		OSPC_PLL_LOCK = 2'b01,
		OSPC_PLL_RUN  = 2'b10
	} ospc_pll_st_t;

endpackage : ospc_pkg

// >>> design/ospc_ready_flag.sv
// Ready flag that follows the source; with gating in force, only while a request is present
`timescale 1ns/10ps
module ospc_ready_flag
(
	// Clock and reset
	input  wire logic  clock,
	input  wire logic  rst,
	// Inputs
	input  wire logic  src_ready,
	input  wire logic  req,
	input  wire logic  gate_need,
	// Flag
	output logic       flag_q
);
	import ospc_pkg::*;

	////////////////////////////////////////////////////////////////
	// With gating in force the flag updates only under a request
	always_ff @(posedge clock)
	begin
		if (rst)
			flag_q <= 1'b0;
		else if (!gate_need || req)
			flag_q <= src_ready;
	end

	gated_hold_a: assert property (@(posedge clock) disable iff (rst)
		(gate_need && !req) |=> $stable(flag_q)) else $error("flag moved without request");

endmodule : ospc_ready_flag

// >>> design/ospc_req_merge.sv
// Merges peripheral clock requests and keeps an oscillator running
`timescale 1ns/10ps
module ospc_req_merge
(
	// Clock and reset
	input  wire logic        clock,
	input  wire logic        rst,
	// Control
	input  wire logic        enable,
	input  wire logic        sleeping,
	input  wire logic [1:0]  periph_req,
	// Result
	output logic             req_q,
	output logic             run_q
);
	import ospc_pkg::*;

	////////////////////////////////////////////////////////////////
	// One request line per oscillator; starts it and gates its flag
	always_ff @(posedge clock)
	begin
		if (rst)
			req_q <= 1'b0;
		else
			req_q <= |periph_req;
	end

	// Run while requested; standby bit never keeps it alive in sleep
	always_ff @(posedge clock)
	begin
		if (rst)
			run_q <= 1'b0;
		else
			run_q <= (|periph_req) | (enable & ~sleeping);
	end

	request_start_a: assert property (@(posedge clock) disable iff (rst)
		(|periph_req) |=> run_q) else $error("requested oscillator not running");
	sleep_stop_a: assert property (@(posedge clock) disable iff (rst)
		(sleeping && !(|periph_req)) |=> !run_q) else $error("oscillator kept alive in sleep");

endmodule : ospc_req_merge

// >>> design/ospc_top.sv
// Oscillator and PLL status controller with register port and interrupt
`timescale 1ns/10ps
module ospc_top
(
	// Clock and reset
	input  wire logic        clock,
	input  wire logic        rst,
	// Register port
	input  wire logic [3:0]  reg_addr,
	input  wire logic [7:0]  reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [7:0]  reg_rdata,
	// Peripheral clock requests: bit0 real-time counter, bit1 timer_type_d
	input  wire logic [1:0]  hf_req,
	input  wire logic [1:0]  lf_req,
	input  wire logic        pll_req,
	// Oscillator readiness from analog cells
	input  wire logic        hf_src_ready,
	input  wire logic        lf_src_ready,
	// Sleep indication
	input  wire logic        sleeping,
	// Oscillator run controls
	output logic             hf_run,
	output logic             lf_run,
	output logic             pll_run,
	// Interrupt
	output logic             irq
);
	import ospc_pkg::*;

	////////////////////////////////////////////////////////////////
	// Control registers
	logic [7:0]    hf_ctrl_q;	// hf_xosc_control_a
	logic [7:0]    lf_ctrl_q;	// lf_xosc_control_a
	logic [7:0]    pll_ctrl_q;	// pll_control_a
	logic [2:0]    irq_stat_q;	// Sticky ready events
	logic [2:0]    irq_mask_q;	// Interrupt mask
	// Ready flags and their event logic
	logic [2:0]    flags_prev_q;	// For rising edge detection
	logic [2:0]    flags;	// Current ready flags
	logic [2:0]    flag_rise;	// Flag set events
	logic [2:0]    clr_vec;	// Write-one-to-clear vector
	// Merged requests, run controls and PLL state
	logic          hf_req_q;	// Merged hf request
	logic          lf_req_q;	// Merged lf request
	logic          hf_run_q;	// hf cell run, before the output flop
	logic          lf_run_q;	// 32 kHz cell run, before the output flop
	logic          pll_ok;	// PLL allowed to run
	logic [7:0]    lock_cnt_q;	// Lock timer
	logic          pll_ready_flag_q;	// pll_ready_flag
	ospc_pll_st_t  pll_st_q;	// PLL controller state
	logic          wr_hf;	// Write to hf control
	logic          wr_lf;	// Write to 32 kHz control
	logic          wr_pll;	// Write to PLL control

	// Write decodes, one per control register
	assign wr_hf  = reg_wr && (reg_addr == OSPC_ADDR_HF_CTRL);
	assign wr_lf  = reg_wr && (reg_addr == OSPC_ADDR_LF_CTRL);
	assign wr_pll = reg_wr && (reg_addr == OSPC_ADDR_PLL_CTRL);

	// Control register writes
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			// Everything off after reset; software enables each source
			hf_ctrl_q  <= OSPC_CTRL_RST;
			lf_ctrl_q  <= OSPC_CTRL_RST;
			pll_ctrl_q <= OSPC_CTRL_RST;
			irq_mask_q <= OSPC_FLAG_RST;
		end
		else
		begin
			// Each register loads only on its own index; other indices are ignored
			if (wr_hf)
				hf_ctrl_q <= reg_wdata;
			if (wr_lf)
				lf_ctrl_q <= reg_wdata;
			if (wr_pll)
				pll_ctrl_q <= reg_wdata;
			// Only three mask bits exist; upper write bits are dropped
			if (reg_wr && (reg_addr == OSPC_ADDR_IRQ_MASK))
				irq_mask_q <= reg_wdata[2:0];
		end
	end

	////////////////////////////////////////////////////////////////
	// Request merging and run control per oscillator
	// Both oscillators share one merge module; only their enables and request inputs differ
	ospc_req_merge u_hf_merge
	(
		.clock      (clock),
		.rst        (rst),
		.enable     (hf_ctrl_q[OSPC_BIT_ENABLE]),
		.sleeping   (sleeping),
		.periph_req (hf_req),
		.req_q      (hf_req_q),
		.run_q      (hf_run_q)
	);

	ospc_req_merge u_lf_merge
	(
		.clock      (clock),
		.rst        (rst),
		.enable     (lf_ctrl_q[OSPC_BIT_ENABLE]),
		.sleeping   (sleeping),
		.periph_req (lf_req),
		.req_q      (lf_req_q),
		.run_q      (lf_run_q)
	);

	////////////////////////////////////////////////////////////////
	// Ready flags; gating applies when standby is set on an external clock
	// Readiness counts only while the cell is told to run, so a stopped cell clears the flag unless gating holds it
	ospc_ready_flag u_external_clock_ready_flag
	(
		.clock     (clock),
		.rst       (rst),
		.src_ready (hf_src_ready & hf_run_q),
		.req       (hf_req_q),
		.gate_need (hf_ctrl_q[OSPC_BIT_HF_EXTERNAL_INPUT_SELECT] & hf_ctrl_q[OSPC_BIT_RUNSTBY]),
		.flag_q    (flags[OSPC_BIT_EXTERNAL_CLOCK_READY_FLAG])
	);

	// The 32 kHz flag never gates; its standby bit has no effect on reporting
	ospc_ready_flag u_lfs
	(
		.clock     (clock),
		.rst       (rst),
		.src_ready (lf_src_ready & lf_run_q),
		.req       (lf_req_q),
		.gate_need (1'b0),
		.flag_q    (flags[OSPC_BIT_LFS])
	);

	assign flags[OSPC_BIT_PLL_READY_FLAG] = pll_ready_flag_q;

	// Gated and unrequested, a clear flag must stay clear
	external_clock_ready_flag_gate_a: assert property (@(posedge clock) disable iff (rst)
		(hf_ctrl_q[OSPC_BIT_HF_EXTERNAL_INPUT_SELECT] && hf_ctrl_q[OSPC_BIT_RUNSTBY] && !hf_req_q && !flags[OSPC_BIT_EXTERNAL_CLOCK_READY_FLAG])
		|=> !flags[OSPC_BIT_EXTERNAL_CLOCK_READY_FLAG]) else $error("external flag set without request");
	// Under a request the flag shows the cell's readiness one cycle later
	external_clock_ready_flag_report_a: assert property (@(posedge clock) disable iff (rst)
		hf_req_q |=> (flags[OSPC_BIT_EXTERNAL_CLOCK_READY_FLAG] == $past(hf_src_ready && hf_run_q)))
		else $error("requested external flag not reporting");

	////////////////////////////////////////////////////////////////
	// PLL: external source needs hf in external-clock mode, never crystal
	// The hf cell must also be running, or the PLL would try to lock on a dead input
	assign pll_ok = pll_ctrl_q[OSPC_BIT_ENABLE] &&
		(!pll_ctrl_q[OSPC_BIT_PLLSRC] || (hf_ctrl_q[OSPC_BIT_HF_EXTERNAL_INPUT_SELECT] && hf_run_q));

	// PLL state machine with lock timer
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			pll_st_q   <= OSPC_PLL_OFF;
			lock_cnt_q <= 8'h00;
		end
		else if (!pll_ok || (sleeping && !pll_req))
		begin
			// Forced stop: PLL disabled, source unusable, or asleep with no requester
			pll_st_q   <= OSPC_PLL_OFF;
			lock_cnt_q <= 8'h00;
		end
		else
		begin
			unique case (pll_st_q)
				OSPC_PLL_OFF:
					// Start locking on the first enabled cycle
					pll_st_q <= OSPC_PLL_LOCK;
				OSPC_PLL_LOCK:
				begin
					// Count lock time before declaring the PLL running
					if (lock_cnt_q >= OSPC_PLL_LOCK_MAX - 8'h01)
						pll_st_q <= OSPC_PLL_RUN;
					else
						lock_cnt_q <= lock_cnt_q + 8'h01;
				end
				OSPC_PLL_RUN:
					// Stay locked until a forced stop
					pll_st_q <= OSPC_PLL_RUN;
				default:
					// Unused code 2'b11 falls back to off
					pll_st_q <= OSPC_PLL_OFF;
			endcase
		end
	end

	// PLL ready flag: standby set without a requester blocks it for as long as that lasts
	// Limitation: software cannot see lock while standby is set and nothing requests the PLL
	always_ff @(posedge clock)
	begin
		if (rst)
			pll_ready_flag_q <= 1'b0;
		else if (pll_ctrl_q[OSPC_BIT_RUNSTBY] && !pll_req)
			pll_ready_flag_q <= 1'b0;
		else
			pll_ready_flag_q <= (pll_st_q == OSPC_PLL_RUN);
	end

	// Standby without a requester keeps the flag low
	pll_ready_flag_block_a: assert property (@(posedge clock) disable iff (rst)
		(pll_ctrl_q[OSPC_BIT_RUNSTBY] && !pll_req) |=> !pll_ready_flag_q) else $error("pll flag set without request");
	// External source on a crystal keeps the PLL stopped
	pll_crystal_a: assert property (@(posedge clock) disable iff (rst)
		(pll_ctrl_q[OSPC_BIT_PLLSRC] && !hf_ctrl_q[OSPC_BIT_HF_EXTERNAL_INPUT_SELECT]) |=> pll_st_q == OSPC_PLL_OFF)
		else $error("pll ran from crystal");
	// Asleep with no requester the PLL is stopped
	pll_sleep_a: assert property (@(posedge clock) disable iff (rst)
		(sleeping && !pll_req) |=> pll_st_q == OSPC_PLL_OFF) else $error("pll kept alive in sleep");
	// The ready flag rises only after the controller reached run
	pll_ready_flag_locked_a: assert property (@(posedge clock) disable iff (rst)
		pll_ready_flag_q |-> $past(pll_st_q == OSPC_PLL_RUN)) else $error("pll flag set before lock");

	////////////////////////////////////////////////////////////////
	// Sticky interrupt status; a new set wins over a clear
	// Edge history resets to the flags' reset value, so no false event follows reset
	assign flag_rise = flags & ~flags_prev_q;
	assign clr_vec   = (reg_wr && (reg_addr == OSPC_ADDR_IRQ_STAT)) ? reg_wdata[2:0] : 3'h0;

	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			flags_prev_q <= OSPC_FLAG_RST;
			irq_stat_q   <= OSPC_FLAG_RST;
		end
		else
		begin
			flags_prev_q <= flags;
			irq_stat_q   <= (irq_stat_q & ~clr_vec) | flag_rise;
		end
	end

	// Interrupt output registered
	// Built from the next status value so it changes in the same cycle as the status register, not one later
	always_ff @(posedge clock)
	begin
		if (rst)
			irq <= 1'b0;
		else
			irq <= |(((irq_stat_q & ~clr_vec) | flag_rise) & irq_mask_q);
	end

	////////////////////////////////////////////////////////////////
	// Read data, one cycle after the strobe; unmapped reads zero
	// Zero outside the answer cycle, so stale data never linger on the port
	always_ff @(posedge clock)
	begin
		if (rst)
			reg_rdata <= 8'h00;
		else if (reg_rd)
		begin
			unique case (reg_addr)
				OSPC_ADDR_HF_CTRL:  reg_rdata <= hf_ctrl_q;
				OSPC_ADDR_LF_CTRL:  reg_rdata <= lf_ctrl_q;
				OSPC_ADDR_PLL_CTRL: reg_rdata <= pll_ctrl_q;
				// Flag registers pad the upper bits with zero
				OSPC_ADDR_STATUS:   reg_rdata <= {5'h00, flags};
				OSPC_ADDR_IRQ_STAT: reg_rdata <= {5'h00, irq_stat_q};
				OSPC_ADDR_IRQ_MASK: reg_rdata <= {5'h00, irq_mask_q};
				default:            reg_rdata <= 8'h00;
			endcase
		end
		else
			reg_rdata <= 8'h00;
	end

	// Run outputs registered
	// The PLL counts as running from the first lock cycle on
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			hf_run  <= 1'b0;
			lf_run  <= 1'b0;
			pll_run <= 1'b0;
		end
		else
		begin
			hf_run  <= hf_run_q;
			lf_run  <= lf_run_q;
			pll_run <= (pll_st_q != OSPC_PLL_OFF);
		end
	end

	////////////////////////////////////////////////////////////////
	// Checks on the interrupt and the register port
	// Interrupt level follows any unmasked status bit unless a write intervenes
	irq_level_a: assert property (@(posedge clock) disable iff (rst)
		(|(irq_stat_q & irq_mask_q) && !reg_wr) |=> irq) else $error("interrupt not raised");
	// Read data are zero outside the answer cycle
	rdata_idle_a: assert property (@(posedge clock) disable iff (rst)
		!reg_rd |=> reg_rdata == 8'h00) else $error("read data outside answer cycle");

endmodule : ospc_top

// >>> dv/ospc_osc_model.sv
// Behavioural oscillator cell whose ready output follows its run input after a start-up time
`timescale 1ns/10ps
module ospc_osc_model
#(
	parameter int START_CYC = 5	// Start-up time in clocks, arbitrary
)
(
	// Clock
	input  wire logic clock,
	// Cell
	input  wire logic run,
	output logic      ready
);
	int cnt_q = 0;	// Clocks since run rose

	////////////////////////////////////////////////////////////////////////////////
	// Ready only after a full start-up; a stop drops it at once, as a real cell would
	always_ff @(posedge clock)
	begin
		if (run !== 1'b1)
		begin
			cnt_q <= 0;
			ready <= 1'b0;
		end
		else
		begin
			if (cnt_q < START_CYC)
			begin
				cnt_q <= cnt_q + 1;
			end
			ready <= (cnt_q >= START_CYC);
		end
	end
endmodule : ospc_osc_model

// >>> dv/test_ospc_top.sv
// Self-checking testbench for the oscillator and PLL status controller
`timescale 1ns/10ps
module test_ospc_top;
	import ospc_pkg::*;
	logic       clock = 1'b0;	// 40 MHz clock
	logic       rst = 1'b1;	// Synchronous reset
	logic [3:0] reg_addr = 4'h0;	// Register port
	logic [7:0] reg_wdata = 8'h00;
	logic       reg_wr = 1'b0;
	logic       reg_rd = 1'b0;
	logic [7:0] reg_rdata;
	logic [1:0] hf_req = 2'h0;	// Peripheral requests
	logic [1:0] lf_req = 2'h0;
	logic       pll_req = 1'b0;
	logic       hf_src_ready;	// From the cell models
	logic       lf_src_ready;
	logic       sleeping = 1'b0;
	logic       hf_run;
	logic       lf_run;
	logic       pll_run;
	logic       irq;
	logic [7:0] rd;	// Last read value
	int         bad_count = 0;
	int         tests_run = 0;
	int         cycles = 0;

	////////////////////////////////////////////////////////////////////////////////
	ospc_top u_ospc_top (.clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .hf_req(hf_req), .lf_req(lf_req),
		.pll_req(pll_req), .hf_src_ready(hf_src_ready), .lf_src_ready(lf_src_ready),
		.sleeping(sleeping), .hf_run(hf_run), .lf_run(lf_run), .pll_run(pll_run), .irq(irq));
	ospc_osc_model u_hf_cell (.clock(clock), .run(hf_run), .ready(hf_src_ready));
	ospc_osc_model u_lf_cell (.clock(clock), .run(lf_run), .ready(lf_src_ready));

	initial
	begin
		forever #12.5 clock = ~clock;
	end

	// Hang guard: the sequence needs well under a thousand clocks
	always @(posedge clock)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			bad_count++;
			tally_and_finish();
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic tick(input int n);
		repeat (n) @(posedge clock);
	endtask : tick

	task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
		@(posedge clock);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge clock);
		reg_wr    <= 1'b0;
	endtask : reg_write

	// Data stand only in the cycle after the strobe; the next edge takes them before they clear
	task automatic reg_read(input logic [3:0] a);
		@(posedge clock);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge clock);
		reg_rd   <= 1'b0;
		@(posedge clock);
		rd = reg_rdata;
	endtask : reg_read

	task automatic check_reg(input string what, input logic [7:0] exp, input logic [7:0] got);
		tests_run++;
		if (got !== exp)
		begin
			bad_count++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask : check_reg

	task automatic check_bit(input string what, input logic exp, input logic got);
		tests_run++;
		if (got !== exp)
		begin
			bad_count++;
			$display("Error %s expected %b seen %b", what, exp, got);
		end
	endtask : check_bit

	task automatic tally_and_finish();
		if (bad_count == 0 && tests_run > 0)
		begin
			$display("All tests passed");
		end
		else
		begin
			$display("Some tests failed");
		end
		$finish;
	endtask : tally_and_finish

	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		tick(20);
		rst <= 1'b0;
		// Reset values, and an unmapped index that must read as zero
		for (int a = 0; a < 7; a++)
		begin
			reg_read(4'(a));
			check_reg("reset value", 8'h00, rd);
		end
		// Standby with external clock input but no request: flag stays clear
		reg_write(OSPC_ADDR_HF_CTRL, 8'h83);
		tick(20);
		reg_read(OSPC_ADDR_STATUS);
		check_reg("status unrequested", 8'h00, rd);
		// A request lets the ready flag report
		hf_req <= 2'h1;
		tick(20);
		reg_read(OSPC_ADDR_STATUS);
		check_reg("status requested", 8'h01, rd);
		reg_read(OSPC_ADDR_IRQ_STAT);
		check_reg("event flags", 8'h01, rd);
		check_bit("irq masked", 1'b0, irq);
		reg_write(OSPC_ADDR_IRQ_MASK, 8'h01);
		tick(2);
		check_bit("irq unmasked", 1'b1, irq);
		reg_write(OSPC_ADDR_IRQ_STAT, 8'h01);
		tick(2);
		check_bit("irq cleared", 1'b0, irq);
		reg_read(OSPC_ADDR_IRQ_STAT);
		check_reg("event flags cleared", 8'h00, rd);
		// Sleep: standby bits alone keep nothing alive, a request does
		reg_write(OSPC_ADDR_LF_CTRL, 8'h81);
		hf_req   <= 2'h0;
		sleeping <= 1'b1;
		tick(4);
		check_bit("hf run asleep", 1'b0, hf_run);
		check_bit("lf run asleep", 1'b0, lf_run);
		hf_req <= 2'h2;
		lf_req <= 2'h1;
		tick(4);
		check_bit("hf run requested", 1'b1, hf_run);
		check_bit("lf run requested", 1'b1, lf_run);
		sleeping <= 1'b0;
		hf_req   <= 2'h0;
		lf_req   <= 2'h0;
		// PLL standby without a request never shows ready
		reg_write(OSPC_ADDR_PLL_CTRL, 8'h81);
		tick(40);
		reg_read(OSPC_ADDR_STATUS);
		check_bit("pll ready unrequested", 1'b0, rd[OSPC_BIT_PLL_READY_FLAG]);
		check_bit("lf ready", 1'b1, rd[OSPC_BIT_LFS]);
		pll_req <= 1'b1;
		tick(40);
		reg_read(OSPC_ADDR_STATUS);
		check_bit("pll ready requested", 1'b1, rd[OSPC_BIT_PLL_READY_FLAG]);
		pll_req <= 1'b0;
		// External PLL source with a crystal stays stopped
		reg_write(OSPC_ADDR_HF_CTRL, 8'h01);
		reg_write(OSPC_ADDR_PLL_CTRL, 8'h03);
		tick(30);
		check_bit("pll run crystal", 1'b0, pll_run);
		reg_write(OSPC_ADDR_HF_CTRL, 8'h03);
		tick(30);
		check_bit("pll run ext clock", 1'b1, pll_run);
		tally_and_finish();
	end
endmodule : test_ospc_top
